// ### rtl/synth_delay_level_power_regs.sv
// serial-port register slice: output invert, delay trims, io level, amplitudes, power-downs
`timescale 1ns/100ps
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - bit 7 at 0x17 inverts output polarity
// - bits 6:0 at 0x17 feedback delay trim
// - bit 7 at 0x18 selects io level
// - bits 6:0 at 0x18 reference delay trim
// - bits 7:6 at 0x19 second output amplitude
// - bits 5:4 at 0x19 first output amplitude
// - bit 3 at 0x19 sleeps mux/divider
// - bit 2 at 0x19 sleeps ref detector, resets 1
// - bit 1 at 0x19 sleeps temperature converter
// - bit 0 at 0x19 sleeps calibration DAC
// - bit 7 at 0x1A chip sleep, keeps contents
// - bit 6 at 0x1A sleeps reference divider, doubler
// - bit 5 at 0x1A sleeps feedback divider
// - bits 3,4 at 0x1A sleep lock detector, oscillator
// - bit 2 at 0x1A sleeps phase detector, pump
// - bit 1 at 0x1A sleeps first buffer, resets 1
// - bit 0 at 0x1A sleeps second buffer, resets 1
// - reset values 0x00, 0x00, 0x04, 0x83
module synth_delay_level_power_regs
	import synth_regs_pkg::*;
(
	input wire logic mclk,
	input wire logic rstn,
	input wire logic spi_sclk,
	input wire logic spi_cs_n,
	input wire logic spi_sdi,
	input wire logic buffer_update,
	input wire logic double_buffer_enable,
	output logic spi_sdo_o,
	output logic spi_sdo_oe,
	output sleep_ctrl_t sleep,
	output trim_ctrl_t trim,
	output logic [1:0] first_output_amplitude,
	output logic [1:0] second_output_amplitude,
	output logic io_logic_level_select
);
	localparam logic [NUM_REGS-1:0][7:0] REG_RESET = {
		RST_MAIN_AND_BLOCK_POWER_DOWN,
		RST_OUTPUT_AMPLITUDE_AND_AUX_POWER_DOWN,
		RST_LOGIC_LEVEL_AND_REFERENCE_DELAY,
		RST_OUTPUT_INVERT_AND_FEEDBACK_DELAY
	};

	typedef struct packed {
		spi_phase_t phase;
		logic [3:0] bit_cnt;
		logic [15:0] shift_in;
		logic read_op;
		logic [ADDR_W-1:0] addr;
		logic [7:0] rd_shift;
		logic sdo;
		logic sdo_oe;
		logic sclk_prev;
		logic update_prev;
		logic update_pulse;
		logic [NUM_REGS-1:0][7:0] regs;
		sleep_ctrl_t sleep;
	} regs_state_t;

	regs_state_t state_q;
	regs_state_t state_d;

	logic sclk_s;
	logic cs_n_s;
	logic sdi_s;
	logic update_s;
	logic buffered_s;
	trim_ctrl_t live_trim;
	logic [15:0] shifted;
	logic [ADDR_W-1:0] next_addr;

	//////////////////////////////////////////////////////////////////////////
	// pins from the host and the update source are asynchronous to mclk
	pin_sync #(
		.W(5),
		.RST_VAL(5'h08)
	) u_pin_sync (
		.mclk(mclk),
		.rstn(rstn),
		.async_in({spi_sclk, spi_cs_n, spi_sdi, buffer_update, double_buffer_enable}),
		.sync_out({sclk_s, cs_n_s, sdi_s, update_s, buffered_s})
	);

	//////////////////////////////////////////////////////////////////////////
	// decoded register access
	function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
		reg_hit = (a >= OFS_OUTPUT_INVERT_AND_FEEDBACK_DELAY) &&
			(a <= OFS_MAIN_AND_BLOCK_POWER_DOWN);
	endfunction

	function automatic logic [1:0] reg_idx(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-1:0] diff;
		diff = a - OFS_OUTPUT_INVERT_AND_FEEDBACK_DELAY;
		reg_idx = diff[1:0];
	endfunction

	function automatic logic [7:0] reg_read(
		input logic [NUM_REGS-1:0][7:0] bank,
		input logic [ADDR_W-1:0] a
	);
		reg_read = reg_hit(a) ? bank[reg_idx(a)] : 8'h00;
	endfunction

	assign shifted = {state_q.shift_in[14:0], sdi_s};
	assign next_addr = state_q.addr + 15'h0001;

	//////////////////////////////////////////////////////////////////////////
	// serial transaction engine: 16-bit instruction (read flag, address), then bytes
	always_comb begin
		state_d = state_q;
		state_d.sclk_prev = sclk_s;
		state_d.update_prev = update_s;
		state_d.update_pulse = update_s && !state_q.update_prev;

		if (cs_n_s) begin
			state_d.phase = SPI_IDLE;
			state_d.bit_cnt = 4'h0;
			state_d.sdo_oe = 1'b0;
			state_d.sdo = 1'b0;
		end else begin
			case (state_q.phase)
				SPI_IDLE: begin
					state_d.phase = SPI_INSTR;
					state_d.bit_cnt = 4'h0;
				end
				SPI_INSTR: begin
					if (sclk_s && !state_q.sclk_prev) begin
						state_d.shift_in = shifted;
						state_d.bit_cnt = state_q.bit_cnt + 4'h1;
						if (state_q.bit_cnt == INSTR_LAST_BIT) begin
							state_d.read_op = shifted[15];
							state_d.addr = shifted[ADDR_W-1:0];
							state_d.phase = SPI_DATA;
							state_d.bit_cnt = 4'h0;
							state_d.rd_shift = reg_read(state_q.regs, shifted[ADDR_W-1:0]);
							state_d.sdo_oe = shifted[15];
						end
					end
				end
				SPI_DATA: begin
					if (sclk_s && !state_q.sclk_prev) begin
						state_d.shift_in = shifted;
						state_d.bit_cnt = state_q.bit_cnt + 4'h1;
						if (state_q.bit_cnt == DATA_LAST_BIT) begin
							state_d.bit_cnt = 4'h0;
							state_d.addr = next_addr;
							state_d.rd_shift = reg_read(state_q.regs, next_addr);
							// unmapped writes are dropped, unmapped reads give zero
							if (!state_q.read_op && reg_hit(state_q.addr)) begin
								state_d.regs[reg_idx(state_q.addr)] = shifted[7:0];
							end
						end
					end else if (!sclk_s && state_q.sclk_prev && state_q.read_op) begin
						state_d.sdo = state_q.rd_shift[7];
						state_d.rd_shift = {state_q.rd_shift[6:0], 1'b0};
					end
				end
				default: begin
					state_d.phase = SPI_IDLE;
				end
			endcase
		end

		// power-down levels follow the bank; chip sleep never touches the bank
		state_d.sleep.chip_sleep = state_d.regs[IDX_MAIN_PD][POS_CHIP];
		state_d.sleep.ref_divider_sleep = state_d.regs[IDX_MAIN_PD][POS_REF_DIV];
		state_d.sleep.feedback_divider_sleep = state_d.regs[IDX_MAIN_PD][POS_FB_DIV];
		state_d.sleep.oscillator_sleep = state_d.regs[IDX_MAIN_PD][POS_OSC];
		state_d.sleep.lock_detector_sleep = state_d.regs[IDX_MAIN_PD][POS_LOCK_DET];
		state_d.sleep.phase_detector_pump_sleep = state_d.regs[IDX_MAIN_PD][POS_PFD_CP];
		state_d.sleep.first_output_buffer_sleep = state_d.regs[IDX_MAIN_PD][POS_OUT1_BUF];
		state_d.sleep.second_output_buffer_sleep = state_d.regs[IDX_MAIN_PD][POS_OUT2_BUF];
		state_d.sleep.osc_mux_divider_sleep = state_d.regs[IDX_AMP_AUX][POS_OSC_MUX_DIV];
		state_d.sleep.ref_detector_sleep = state_d.regs[IDX_AMP_AUX][POS_REF_DET];
		state_d.sleep.temp_converter_sleep = state_d.regs[IDX_AMP_AUX][POS_TEMP_CONV];
		state_d.sleep.cal_dac_sleep = state_d.regs[IDX_AMP_AUX][POS_CAL_DAC];
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			state_q <= '0;
			state_q.sclk_prev <= 1'b0;
			state_q.regs <= REG_RESET;
			state_q.sleep.chip_sleep <= RST_MAIN_AND_BLOCK_POWER_DOWN[POS_CHIP];
			state_q.sleep.first_output_buffer_sleep <= RST_MAIN_AND_BLOCK_POWER_DOWN[POS_OUT1_BUF];
			state_q.sleep.second_output_buffer_sleep <= RST_MAIN_AND_BLOCK_POWER_DOWN[POS_OUT2_BUF];
			state_q.sleep.ref_detector_sleep <= RST_OUTPUT_AMPLITUDE_AND_AUX_POWER_DOWN[POS_REF_DET];
		end else begin
			state_q <= state_d;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// double-bufferable fields pass through the shadow stage
	assign live_trim.output_polarity_invert = state_q.regs[IDX_INV_FB][POS_POLARITY_INVERT];
	assign live_trim.feedback_delay_trim = state_q.regs[IDX_INV_FB][POS_DELAY_MSB:0];
	assign live_trim.reference_delay_trim = state_q.regs[IDX_LVL_REF][POS_DELAY_MSB:0];

	trim_shadow u_trim_shadow (
		.mclk(mclk),
		.rstn(rstn),
		.buffered(buffered_s),
		.update_pulse(state_q.update_pulse),
		.live(live_trim),
		.applied(trim)
	);

	//////////////////////////////////////////////////////////////////////////
	// outputs, all from flops
	assign spi_sdo_o = state_q.sdo;
	assign spi_sdo_oe = state_q.sdo_oe;
	assign sleep = state_q.sleep;
	assign io_logic_level_select = state_q.regs[IDX_LVL_REF][POS_IO_LEVEL];
	assign second_output_amplitude = state_q.regs[IDX_AMP_AUX][POS_AMP2_MSB:POS_AMP2_LSB];
	assign first_output_amplitude = state_q.regs[IDX_AMP_AUX][POS_AMP1_MSB:POS_AMP1_LSB];
endmodule

// ### common/synth_regs_pkg.sv
// constants, field layouts and carriers for the synthesizer configuration slice
package synth_regs_pkg;

	localparam int ADDR_W = 15;
	localparam int DATA_W = 8;
	localparam int NUM_REGS = 4;
	localparam logic [3:0] INSTR_LAST_BIT = 4'hF;
	localparam logic [3:0] DATA_LAST_BIT = 4'h7;

	// register offsets
	localparam logic [ADDR_W-1:0] OFS_OUTPUT_INVERT_AND_FEEDBACK_DELAY = 15'h0017;
	localparam logic [ADDR_W-1:0] OFS_LOGIC_LEVEL_AND_REFERENCE_DELAY = 15'h0018;
	localparam logic [ADDR_W-1:0] OFS_OUTPUT_AMPLITUDE_AND_AUX_POWER_DOWN = 15'h0019;
	localparam logic [ADDR_W-1:0] OFS_MAIN_AND_BLOCK_POWER_DOWN = 15'h001A;

	// index of each register in the bank
	localparam int IDX_INV_FB = 0;
	localparam int IDX_LVL_REF = 1;
	localparam int IDX_AMP_AUX = 2;
	localparam int IDX_MAIN_PD = 3;

	// reset values
	localparam logic [7:0] RST_OUTPUT_INVERT_AND_FEEDBACK_DELAY = 8'h00;
	localparam logic [7:0] RST_LOGIC_LEVEL_AND_REFERENCE_DELAY = 8'h00;
	localparam logic [7:0] RST_OUTPUT_AMPLITUDE_AND_AUX_POWER_DOWN = 8'h04;
	localparam logic [7:0] RST_MAIN_AND_BLOCK_POWER_DOWN = 8'h83;

	// field positions
	localparam int POS_POLARITY_INVERT = 7;
	localparam int POS_IO_LEVEL = 7;
	localparam int POS_DELAY_MSB = 6;
	localparam int POS_AMP2_MSB = 7;
	localparam int POS_AMP2_LSB = 6;
	localparam int POS_AMP1_MSB = 5;
	localparam int POS_AMP1_LSB = 4;
	localparam int POS_OSC_MUX_DIV = 3;
	localparam int POS_REF_DET = 2;
	localparam int POS_TEMP_CONV = 1;
	localparam int POS_CAL_DAC = 0;
	localparam int POS_CHIP = 7;
	localparam int POS_REF_DIV = 6;
	localparam int POS_FB_DIV = 5;
	localparam int POS_OSC = 4;
	localparam int POS_LOCK_DET = 3;
	localparam int POS_PFD_CP = 2;
	localparam int POS_OUT1_BUF = 1;
	localparam int POS_OUT2_BUF = 0;

	localparam int TRIM_W = 15;

	typedef enum logic [1:0] {
		SPI_IDLE,
		SPI_INSTR,
		SPI_DATA
	} spi_phase_t;

	typedef struct packed {
		logic chip_sleep;
		logic ref_divider_sleep;
		logic feedback_divider_sleep;
		logic oscillator_sleep;
		logic lock_detector_sleep;
		logic phase_detector_pump_sleep;
		logic first_output_buffer_sleep;
		logic second_output_buffer_sleep;
		logic osc_mux_divider_sleep;
		logic ref_detector_sleep;
		logic temp_converter_sleep;
		logic cal_dac_sleep;
	} sleep_ctrl_t;

	typedef struct packed {
		logic output_polarity_invert;
		logic [6:0] feedback_delay_trim;
		logic [6:0] reference_delay_trim;
	} trim_ctrl_t;

endpackage

// ### rtl/pin_sync.sv
// two-flop synchroniser for a group of asynchronous pins
`timescale 1ns/100ps
module pin_sync #(
	parameter int W = 5,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} sync_state_t;

	sync_state_t state_q;
	sync_state_t state_d;

	always_comb begin
		state_d.meta = async_in;
		state_d.stable = state_q.meta;
	end

	// reset to each pin's idle level, so no false edge or select follows reset
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			state_q <= {RST_VAL, RST_VAL};
		end else begin
			state_q <= state_d;
		end
	end

	assign sync_out = state_q.stable;
endmodule

// ### rtl/trim_shadow.sv
// shadow stage for the double-bufferable invert and delay fields
`timescale 1ns/100ps
module trim_shadow
	import synth_regs_pkg::*;
(
	input wire logic mclk,
	input wire logic rstn,
	input wire logic buffered,
	input wire logic update_pulse,
	input wire trim_ctrl_t live,
	output trim_ctrl_t applied
);
	typedef struct packed {
		trim_ctrl_t applied;
	} shadow_state_t;

	shadow_state_t state_q;
	shadow_state_t state_d;

	// unbuffered fields track the bank directly, buffered ones wait for the update event
	always_comb begin
		state_d = state_q;
		if (!buffered || update_pulse) begin
			state_d.applied = live;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	assign applied = state_q.applied;
endmodule

// ### dv/synth_regs_properties.sv
// port-level assertions for the configuration register slice
`timescale 1ns/100ps
module synth_regs_properties
	import synth_regs_pkg::*;
(
	input wire logic mclk,
	input wire logic rstn,
	input wire logic spi_cs_n,
	input wire logic buffer_update,
	input wire logic double_buffer_enable,
	input wire logic spi_sdo_oe,
	input wire sleep_ctrl_t sleep,
	input wire trim_ctrl_t trim,
	input wire logic [1:0] first_output_amplitude,
	input wire logic [1:0] second_output_amplitude,
	input wire logic io_logic_level_select
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);
	//////////////////////////////////////////////////////////////////////////////
	property p_rst_sleep; $rose(rstn) |-> sleep == 12'h834; endproperty
	property p_rst_out;
		$rose(rstn) |-> trim == 15'h0000 && first_output_amplitude == 2'h0
			&& second_output_amplitude == 2'h0 && !io_logic_level_select;
	endproperty
	// no frame for 8 cycles means no write can still be landing
	property p_sleep_hold; spi_cs_n [*8] |-> $stable(sleep); endproperty
	property p_amp_hold;
		spi_cs_n [*8] |-> $stable(first_output_amplitude) && $stable(second_output_amplitude);
	endproperty
	property p_level_hold; spi_cs_n [*8] |-> $stable(io_logic_level_select); endproperty
	property p_trim_hold;
		(spi_cs_n && $stable(buffer_update) && $stable(double_buffer_enable)) [*8]
			|-> $stable(trim);
	endproperty
	property p_trim_wait;
		(double_buffer_enable && !buffer_update) [*8] |-> $stable(trim);
	endproperty
	property p_chip_keep;
		$rose(sleep.chip_sleep) |-> $stable(first_output_amplitude)
			&& $stable(sleep.ref_detector_sleep) && $stable(io_logic_level_select);
	endproperty
	a_rst_sleep: assert property (p_rst_sleep) else $error("sleep reset");
	a_rst_out: assert property (p_rst_out) else $error("output reset");
	a_sleep_hold: assert property (p_sleep_hold) else $error("sleep moved");
	a_amp_hold: assert property (p_amp_hold) else $error("amplitude moved");
	a_level_hold: assert property (p_level_hold) else $error("level moved");
	a_trim_hold: assert property (p_trim_hold) else $error("trim moved");
	a_trim_wait: assert property (p_trim_wait) else $error("trim not held");
	a_chip_keep: assert property (p_chip_keep) else $error("chip sleep lost state");
	c_chip_wake: cover property ($fell(sleep.chip_sleep));
	c_read: cover property ($rose(spi_sdo_oe));
	c_trim: cover property (!$stable(trim));
endmodule
bind synth_delay_level_power_regs synth_regs_properties synth_regs_properties_i (
	.mclk(mclk),
	.rstn(rstn),
	.spi_cs_n(spi_cs_n),
	.buffer_update(buffer_update),
	.double_buffer_enable(double_buffer_enable),
	.spi_sdo_oe(spi_sdo_oe),
	.sleep(sleep),
	.trim(trim),
	.first_output_amplitude(first_output_amplitude),
	.second_output_amplitude(second_output_amplitude),
	.io_logic_level_select(io_logic_level_select)
);

// ### dv/serial_host.sv
// host controller model for the serial register port
`timescale 1ns/100ps
module serial_host (
	input wire logic mclk,
	input wire logic spi_sdo_o,
	input wire logic spi_sdo_oe,
	output logic spi_sclk,
	output logic spi_cs_n,
	output logic spi_sdi
);
	initial begin
		spi_sclk = 1'b0;
		spi_cs_n = 1'b1;
		spi_sdi = 1'b0;
	end
	// half periods of 6 mclk leave margin over the synchroniser
	task automatic hold(input int n);
		repeat (n) @(negedge mclk);
	endtask
	// nbits 24 moves one byte, 32 streams two; anything between cuts the frame
	task automatic xfer(input logic [15:0] ins, input logic [15:0] wd, input int nbits,
		output logic [15:0] rd);
		logic [31:0] w;
		w = {ins, wd};
		rd = 16'h0000;
		spi_cs_n = 1'b0;
		hold(6);
		for (int i = 0; i < nbits; i++) begin
			spi_sdi = w[31-i];
			hold(6);
			// a released line reads inverted, so a missing enable spoils the data
			if (i >= 16)
				rd = {rd[14:0], spi_sdo_oe ? spi_sdo_o : ~spi_sdo_o};
			spi_sclk = 1'b1;
			hold(6);
			spi_sclk = 1'b0;
		end
		hold(6);
		spi_cs_n = 1'b1;
		hold(10);
	endtask
endmodule

// ### dv/tb.sv
// self-checking bench for the configuration register slice
`timescale 1ns/100ps
module tb
	import synth_regs_pkg::*;
;
	logic mclk = 1'b0;
	logic rstn = 1'b0;
	logic buffer_update = 1'b0;
	logic double_buffer_enable = 1'b0;
	logic spi_sclk, spi_cs_n, spi_sdi, spi_sdo_o, spi_sdo_oe;
	sleep_ctrl_t sleep;
	trim_ctrl_t trim;
	logic [1:0] first_output_amplitude, second_output_amplitude;
	logic io_logic_level_select;
	int failures = 0;
	int cmp_count = 0;
	int m[4];
	logic [14:0] app;
	logic [15:0] rd, sw;
	always #2.5 mclk = ~mclk;
	synth_delay_level_power_regs synth_delay_level_power_regs_i (
		.mclk(mclk),
		.rstn(rstn),
		.spi_sclk(spi_sclk),
		.spi_cs_n(spi_cs_n),
		.spi_sdi(spi_sdi),
		.buffer_update(buffer_update),
		.double_buffer_enable(double_buffer_enable),
		.spi_sdo_o(spi_sdo_o),
		.spi_sdo_oe(spi_sdo_oe),
		.sleep(sleep),
		.trim(trim),
		.first_output_amplitude(first_output_amplitude),
		.second_output_amplitude(second_output_amplitude),
		.io_logic_level_select(io_logic_level_select)
	);
	serial_host serial_host_i (
		.mclk(mclk),
		.spi_sdo_o(spi_sdo_o),
		.spi_sdo_oe(spi_sdo_oe),
		.spi_sclk(spi_sclk),
		.spi_cs_n(spi_cs_n),
		.spi_sdi(spi_sdi)
	);
	//////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input int a, input logic [7:0] d, input int n = 24);
		serial_host_i.xfer({1'b0, a[14:0]}, {d, 8'h00}, n, rd);
		if (n == 24 && a >= 8'h17 && a <= 8'h1A)
			m[a-8'h17] = d;
	endtask
	task automatic rdchk(input int a);
		int e;
		serial_host_i.xfer({1'b1, a[14:0]}, 16'h0000, 24, rd);
		e = (a >= 8'h17 && a <= 8'h1A) ? m[a-8'h17] : 0;
		chk("read", rd, e[7:0]);
	endtask
	task automatic outs();
		chk("sleep", sleep, {m[3][7:0], m[2][3:0]});
		chk("amp1", first_output_amplitude, m[2][5:4]);
		chk("amp2", second_output_amplitude, m[2][7:6]);
		chk("level", io_logic_level_select, m[1][7]);
		chk("trim", trim, double_buffer_enable ? app : {m[0][7:0], m[1][6:0]});
	endtask
	task automatic do_reset();
		rstn = 1'b0;
		m = '{8'h00, 8'h00, 8'h04, 8'h83};
		app = 15'h0000;
		repeat (10) @(negedge mclk);
		rstn = 1'b1;
		repeat (4) @(negedge mclk);
	endtask
	task automatic bump();
		buffer_update = 1'b1;
		repeat (6) @(negedge mclk);
		buffer_update = 1'b0;
		repeat (6) @(negedge mclk);
		app = {m[0][7:0], m[1][6:0]};
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	//////////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'h311354dc));
		do_reset();
		outs();
		for (int a = 8'h16; a <= 8'h1B; a++) rdchk(a);
		for (int k = 0; k < 12; k++) begin
			wr(8'h16 + int'($urandom_range(5)), 8'($urandom()));
			outs();
		end
		for (int a = 8'h16; a <= 8'h1B; a++) rdchk(a);
		for (int v = 0; v <= 1; v++) begin
			wr(8'h19, v ? 8'hFF : 8'h00);
			wr(8'h1A, v ? 8'hFF : 8'h00);
			outs();
			rdchk(8'h19);
		end
		double_buffer_enable = 1'b1;
		bump();
		outs();
		wr(8'h17, 8'($urandom()));
		wr(8'h18, 8'($urandom()));
		outs();
		bump();
		outs();
		double_buffer_enable = 1'b0;
		repeat (6) @(negedge mclk);
		wr(8'h1A, 8'h5A, 20);
		outs();
		rdchk(8'h1A);
		sw = 16'($urandom());
		serial_host_i.xfer({1'b0, OFS_OUTPUT_AMPLITUDE_AND_AUX_POWER_DOWN}, sw, 32, rd);
		m[IDX_AMP_AUX] = sw[15:8];
		m[IDX_MAIN_PD] = sw[7:0];
		outs();
		serial_host_i.xfer({1'b1, OFS_OUTPUT_AMPLITUDE_AND_AUX_POWER_DOWN}, 16'h0000, 32, rd);
		chk("stream", rd, sw);
		do_reset();
		outs();
		rdchk(8'h1A);
		wrap_up();
	end
	initial begin
		#400us;
		failures++;
		wrap_up();
	end
endmodule
